// ===== core/alu_pkg.sv
// Constants and types shared by the add/AND datapath and its adder.
// Assumes one core clock and a decoder that presents one decoded operation per cycle.
package alu_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_WIDTH = 8;
	localparam int ADDR_WIDTH = 6;
	localparam int BIT_SEL_WIDTH = 3;
	localparam int HALF_CARRY_POS = 4;

	// ==========================================================
	// Operand address limits per page
	localparam logic [5:0] DIRECT_ADDR_MIN = 6'h00;
	localparam logic [5:0] DIRECT_ADDR_MAX = 6'h3f;
	localparam logic [5:0] CONTROL_ADDR_MIN = 6'h05;
	localparam logic [5:0] CONTROL_ADDR_MAX = 6'h0f;
	localparam logic [5:0] SPECIAL_ADDR_MIN = 6'h00;
	localparam logic [5:0] SPECIAL_ADDR_MAX = 6'h0f;

	// ==========================================================
	// Destination selector values
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_REG = 1'b1;

	// ==========================================================
	// Reset values (reset stands for power-up)
	localparam logic [7:0] WORK_REG_RESET = 8'h00;
	localparam logic ZERO_FLAG_RESET = 1'b0;
	localparam logic HALF_CARRY_FLAG_RESET = 1'b0;
	localparam logic CARRY_FLAG_RESET = 1'b0;
	localparam logic POWER_DOWN_FLAG_RESET = 1'b1;
	localparam logic TIMEOUT_FLAG_RESET = 1'b1;

	// ==========================================================
	// Timing: every operation here completes in one cycle
	localparam int CLK_PERIOD_NS = 8;
	localparam int OP_CYCLES = 1;

	// ==========================================================
	// Decoded operations
	typedef enum logic [3:0] {
		NOP_OP = 4'h0,
		ADD_REG_WITH_CARRY_OP = 4'h1,
		ADD_REG_OP = 4'h2,
		ADD_IMM_WITH_CARRY_OP = 4'h3,
		ADD_IMM_OP = 4'h4,
		AND_REG_OP = 4'h5,
		BIT_CLEAR_OP = 4'h6,
		WATCHDOG_KICK_OP = 4'h7,
		SLEEP_OP = 4'h8,
		SUB_REG_OP = 4'h9
	} op_type;

	// Register pages
	typedef enum logic [1:0] {
		DIRECT_PAGE = 2'b00,
		CONTROL_PAGE = 2'b01,
		SPECIAL_PAGE = 2'b10
	} page_type;

endpackage

// ===== core/alu_adder.sv
// Eight-bit adder with carry in, carry out and half carry.
// Purely combinational; the caller registers the results.
module alu_adder
	import alu_pkg::*;
(
	input wire logic [alu_pkg::DATA_WIDTH-1:0] addendA,
	input wire logic [alu_pkg::DATA_WIDTH-1:0] addendB,
	input wire logic carryIn,
	output logic [alu_pkg::DATA_WIDTH-1:0] sum,
	output logic carryOut,
	output logic halfCarry
);

	// ==========================================================
	// Low nibble first, so the half carry is a real carry and not a guess
	logic [HALF_CARRY_POS:0] lowSum;
	logic [DATA_WIDTH-HALF_CARRY_POS:0] highSum;

	assign lowSum = {1'b0, addendA[HALF_CARRY_POS-1:0]}
		+ {1'b0, addendB[HALF_CARRY_POS-1:0]}
		+ {{HALF_CARRY_POS{1'b0}}, carryIn};
	assign highSum = {1'b0, addendA[DATA_WIDTH-1:HALF_CARRY_POS]}
		+ {1'b0, addendB[DATA_WIDTH-1:HALF_CARRY_POS]}
		+ {{(DATA_WIDTH-HALF_CARRY_POS){1'b0}}, lowSum[HALF_CARRY_POS]};
	assign sum = {highSum[DATA_WIDTH-HALF_CARRY_POS-1:0], lowSum[HALF_CARRY_POS-1:0]};
	assign halfCarry = lowSum[HALF_CARRY_POS];
	assign carryOut = highSum[DATA_WIDTH-HALF_CARRY_POS];

endmodule // alu_adder

// ===== core/mcu_alu_add_and_flags.sv
// Add, add-with-carry, AND and bit-clear datapath with status flags.
// Assumes the sequencer presents the addressed register value on regRdData in the
// same cycle as the operation, and commits regWr* one cycle later.
module mcu_alu_add_and_flags
	import alu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic opValid,
	input wire alu_pkg::op_type opCode,
	input wire alu_pkg::page_type regPage,
	input wire logic [alu_pkg::ADDR_WIDTH-1:0] regAddr,
	input wire logic destSel,
	input wire logic [alu_pkg::DATA_WIDTH-1:0] immData,
	input wire logic [alu_pkg::BIT_SEL_WIDTH-1:0] bitSel,
	input wire logic [alu_pkg::DATA_WIDTH-1:0] regRdData,
	input wire logic watchdogTimeout,
	output logic [alu_pkg::DATA_WIDTH-1:0] workReg,
	output logic regWrEn,
	output alu_pkg::page_type regWrPage,
	output logic [alu_pkg::ADDR_WIDTH-1:0] regWrAddr,
	output logic [alu_pkg::DATA_WIDTH-1:0] regWrData,
	output logic opDone,
	output logic opReject,
	output logic zeroFlag,
	output logic halfCarryFlag,
	output logic carryFlag,
	output logic powerDownFlag,
	output logic timeoutFlag
);

	// ==========================================================
	// Address range check per page
	function automatic logic addrLegal(input page_type page, input logic [ADDR_WIDTH-1:0] addr);
		logic ok;
		ok = 1'b0;
		if (page == DIRECT_PAGE)
			ok = (addr >= DIRECT_ADDR_MIN) && (addr <= DIRECT_ADDR_MAX);
		else if (page == CONTROL_PAGE)
			ok = (addr >= CONTROL_ADDR_MIN) && (addr <= CONTROL_ADDR_MAX);
		else if (page == SPECIAL_PAGE)
			ok = (addr >= SPECIAL_ADDR_MIN) && (addr <= SPECIAL_ADDR_MAX);
		return ok;
	endfunction

	// ==========================================================
	// Operation classes
	logic taken;
	logic isAddRegCarry;
	logic isAddReg;
	logic isAddImmCarry;
	logic isAddImm;
	logic isAnd;
	logic isBitClear;
	logic isSub;
	logic isKick;
	logic isSleep;
	logic usesReg;
	logic isArith;
	logic useImm;
	logic useCarry;
	logic addrOk;
	logic accept;

	assign taken = clkEn && opValid;
	assign isAddRegCarry = opCode == ADD_REG_WITH_CARRY_OP;
	assign isAddReg = opCode == ADD_REG_OP;
	assign isAddImmCarry = opCode == ADD_IMM_WITH_CARRY_OP;
	assign isAddImm = opCode == ADD_IMM_OP;
	assign isAnd = opCode == AND_REG_OP;
	assign isBitClear = opCode == BIT_CLEAR_OP;
	assign isSub = opCode == SUB_REG_OP;
	assign isKick = opCode == WATCHDOG_KICK_OP;
	assign isSleep = opCode == SLEEP_OP;
	assign usesReg = isAddRegCarry || isAddReg || isAnd || isBitClear || isSub;
	assign isArith = isAddRegCarry || isAddReg || isAddImmCarry || isAddImm || isSub;
	assign useImm = isAddImmCarry || isAddImm;
	assign useCarry = isAddRegCarry || isAddImmCarry;
	// Out-of-range operands are refused whole: nothing is written, no flag moves
	assign addrOk = !usesReg || addrLegal(regPage, regAddr);
	assign accept = taken && addrOk;

	// ==========================================================
	// Adder operands; subtraction is register plus inverted work plus one
	logic [DATA_WIDTH-1:0] addendA;
	logic [DATA_WIDTH-1:0] addendB;
	logic adderCarryIn;
	logic [DATA_WIDTH-1:0] addSum;
	logic addCarry;
	logic addHalf;

	assign addendA = isSub ? regRdData : workReg;
	assign addendB = useImm ? immData : (isSub ? ~workReg : regRdData);
	assign adderCarryIn = useCarry ? carryFlag : isSub;

	alu_adder adder (
		.addendA(addendA),
		.addendB(addendB),
		.carryIn(adderCarryIn),
		.sum(addSum),
		.carryOut(addCarry),
		.halfCarry(addHalf)
	);

	// ==========================================================
	// Bit-clear mask, one lane per bit position
	logic [DATA_WIDTH-1:0] clearMask;
	genvar lane;
	generate
		for (lane = 0; lane < DATA_WIDTH; lane++)
		begin : g_mask
			assign clearMask[lane] = (bitSel != BIT_SEL_WIDTH'(lane));
		end
	endgenerate

	// ==========================================================
	// Result and destination selection
	logic [DATA_WIDTH-1:0] result;
	logic toWork;
	logic toReg;

	assign result = isArith ? addSum
		: isAnd ? (workReg & regRdData)
		: (regRdData & clearMask);
	// Immediate forms always land in the work register
	assign toWork = accept && (useImm || ((isAddRegCarry || isAddReg || isAnd || isSub)
		&& destSel == DEST_WORK));
	assign toReg = accept && (isBitClear || ((isAddRegCarry || isAddReg || isAnd || isSub)
		&& destSel == DEST_REG));

	// ==========================================================
	// Next values of the flags
	logic next_zeroFlag;
	logic next_halfCarryFlag;
	logic next_carryFlag;
	logic next_powerDownFlag;
	logic next_timeoutFlag;

	assign next_zeroFlag = (accept && (isArith || isAnd)) ? (result == 8'h00) : zeroFlag;
	assign next_halfCarryFlag = (accept && isArith) ? addHalf : halfCarryFlag;
	assign next_carryFlag = (accept && isArith) ? addCarry : carryFlag;
	assign next_powerDownFlag = (accept && isKick) ? 1'b1
		: (accept && isSleep) ? 1'b0 : powerDownFlag;
	// A timeout in the same cycle as a kick or sleep wins, so the event is not lost
	assign next_timeoutFlag = (clkEn && watchdogTimeout) ? 1'b0
		: (accept && (isKick || isSleep)) ? 1'b1 : timeoutFlag;

	// ==========================================================
	// Flag registers; reset stands for power-up
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			zeroFlag <= ZERO_FLAG_RESET;
			halfCarryFlag <= HALF_CARRY_FLAG_RESET;
			carryFlag <= CARRY_FLAG_RESET;
			powerDownFlag <= POWER_DOWN_FLAG_RESET;
			timeoutFlag <= TIMEOUT_FLAG_RESET;
		end
		else if (clkEn)
		begin
			zeroFlag <= next_zeroFlag;
			halfCarryFlag <= next_halfCarryFlag;
			carryFlag <= next_carryFlag;
			powerDownFlag <= next_powerDownFlag;
			timeoutFlag <= next_timeoutFlag;
		end
	end

	// ==========================================================
	// Work register and write-back port
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			workReg <= WORK_REG_RESET;
			regWrEn <= 1'b0;
			regWrPage <= DIRECT_PAGE;
			regWrAddr <= '0;
			regWrData <= '0;
		end
		else if (clkEn)
		begin
			if (toWork)
				workReg <= result;
			regWrEn <= toReg;
			regWrPage <= regPage;
			regWrAddr <= regAddr;
			regWrData <= result;
		end
	end

	// ==========================================================
	// Completion and refusal pulses, one cycle each
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			opDone <= 1'b0;
			opReject <= 1'b0;
		end
		else if (clkEn)
		begin
			opDone <= accept;
			opReject <= taken && !addrOk;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_carry_add;
		accept && (isAddReg || isAddImm)
			|=> carryFlag == ((9'($past(workReg))
			+ 9'($past(useImm ? immData : regRdData))) > 9'h0ff);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry wrong");

	property p_work_dest;
		accept && isAddReg && destSel == DEST_WORK
			|=> workReg == $past(workReg + regRdData) && !regWrEn;
	endproperty
	a_work_dest: assert property (p_work_dest) else $error("work dest wrong");

	property p_reg_dest;
		accept && isAnd && destSel == DEST_REG
			|=> regWrEn && regWrData == ($past(workReg) & $past(regRdData))
			&& workReg == $past(workReg);
	endproperty
	a_reg_dest: assert property (p_reg_dest) else $error("reg dest wrong");

	property p_control_range;
		taken && usesReg && regPage == CONTROL_PAGE && regAddr < CONTROL_ADDR_MIN
			|=> opReject && !opDone && !regWrEn;
	endproperty
	a_control_range: assert property (p_control_range) else $error("range not refused");

	property p_special_range;
		taken && usesReg && regPage == SPECIAL_PAGE && regAddr > SPECIAL_ADDR_MAX
			|=> opReject && $stable(workReg);
	endproperty
	a_special_range: assert property (p_special_range) else $error("special not refused");

	property p_direct_ok;
		taken && usesReg && regPage == DIRECT_PAGE |=> opDone && !opReject;
	endproperty
	a_direct_ok: assert property (p_direct_ok) else $error("direct refused");

	property p_sleep;
		accept && isSleep && !watchdogTimeout |=> !powerDownFlag && timeoutFlag;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_timeout;
		clkEn && watchdogTimeout |=> !timeoutFlag;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not cleared");

	property p_adc_imm;
		accept && isAddImmCarry
			|=> workReg == 8'($past(workReg) + $past(immData) + {7'h00, $past(carryFlag)});
	endproperty
	a_adc_imm: assert property (p_adc_imm) else $error("imm add wrong");

	// Register form with carry, written back to the page register
	property p_adc_reg;
		accept && isAddRegCarry && destSel == DEST_REG
			|=> regWrEn && $stable(workReg)
			&& regWrData == 8'($past(regRdData) + $past(workReg) + {7'h00, $past(carryFlag)});
	endproperty
	a_adc_reg: assert property (p_adc_reg) else $error("reg add with carry wrong");

	// Plain immediate add never requests a register write
	property p_add_imm;
		accept && isAddImm |=> !regWrEn && workReg == 8'($past(workReg) + $past(immData));
	endproperty
	a_add_imm: assert property (p_add_imm) else $error("plain imm add wrong");

	property p_kick;
		accept && isKick && !watchdogTimeout |=> powerDownFlag && timeoutFlag;
	endproperty
	a_kick: assert property (p_kick) else $error("kick flags wrong");

	property p_bit_clear;
		accept && isBitClear
			|=> $stable(zeroFlag) && $stable(carryFlag) && $stable(halfCarryFlag)
			&& regWrEn && regWrData[$past(bitSel)] == 1'b0;
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

	property p_zero;
		accept && (isArith || isAnd) |=> zeroFlag == (regWrData == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_half;
		accept && isAddImm
			|=> halfCarryFlag == ((5'($past(workReg[3:0])) + 5'($past(immData[3:0]))) > 5'h0f);
	endproperty
	a_half: assert property (p_half) else $error("half carry wrong");

	property p_sub_carry;
		accept && isSub |=> carryFlag == ($past(regRdData) >= $past(workReg));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("borrow wrong");

	c_add_carry: cover property (accept && isAddRegCarry && carryFlag ##1 carryFlag);
	c_reject: cover property (opReject);
	c_sleep_then_kick: cover property (accept && isSleep ##[1:4] accept && isKick);
	c_zero_result: cover property (accept && isAnd ##1 zeroFlag);
	c_frozen_offer: cover property (!clkEn && opValid);

endmodule // mcu_alu_add_and_flags

// ===== verification/reg_file_model.sv
// Register-page model standing in for the sequencer's register file.
// Assumes one core clock; reads are combinational, writes commit on regWrEn.
module reg_file_model
	import alu_pkg::*;
(
	input wire logic clk,
	input wire logic regWrEn,
	input wire alu_pkg::page_type regWrPage,
	input wire logic [alu_pkg::ADDR_WIDTH-1:0] regWrAddr,
	input wire logic [alu_pkg::DATA_WIDTH-1:0] regWrData,
	input wire alu_pkg::page_type regPage,
	input wire logic [alu_pkg::ADDR_WIDTH-1:0] regAddr,
	output logic [alu_pkg::DATA_WIDTH-1:0] regRdData
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Storage, all four page codes so a refused page still reads
	logic [7:0] mem [0:3][0:63];

	// Same-cycle read; a write-back is seen one cycle after regWrEn
	assign regRdData = mem[regPage][regAddr];

	// Write-back from the datapath
	always @(posedge clk)
		if (regWrEn)
			mem[regWrPage][regWrAddr] <= regWrData;

	// Bench preload of the operand about to be used
	task automatic poke(input page_type p, input logic [5:0] a, input logic [7:0] v);
		mem[p][a] = v;
	endtask
endmodule // reg_file_model

// ===== verification/tb_mcu_alu_add_and_flags.sv
// Self-checking bench for the add/AND datapath and its status flags.
// Assumes the register-page model answers reads in the cycle of the operation.
module tb_mcu_alu_add_and_flags;
	timeunit 1ns;
	timeprecision 100ps;
	import alu_pkg::*;

	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic opValid = 1'b0;
	op_type opCode = NOP_OP;
	page_type regPage = DIRECT_PAGE;
	logic [5:0] regAddr = 6'h00;
	logic destSel = 1'b0;
	logic [7:0] immData = 8'h00;
	logic [2:0] bitSel = 3'h0;
	logic [7:0] regRdData;
	logic watchdogTimeout = 1'b0;
	logic [7:0] workReg;
	logic regWrEn;
	page_type regWrPage;
	logic [5:0] regWrAddr;
	logic [7:0] regWrData;
	logic opDone;
	logic opReject;
	logic zeroFlag;
	logic halfCarryFlag;
	logic carryFlag;
	logic powerDownFlag;
	logic timeoutFlag;
	int fails = 0;
	int testsRun = 0;
	int cycles = 0;
	page_type rp [3] = '{CONTROL_PAGE, SPECIAL_PAGE, page_type'(2'h3)};
	logic [5:0] ra [3] = '{6'h04, 6'h10, 6'h00};

	// ==========================================================
	// Clock, watchdog on the bench itself
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			report_and_stop();
		end
	end

	mcu_alu_add_and_flags dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .opValid(opValid),
		.opCode(opCode), .regPage(regPage), .regAddr(regAddr), .destSel(destSel),
		.immData(immData), .bitSel(bitSel), .regRdData(regRdData),
		.watchdogTimeout(watchdogTimeout), .workReg(workReg), .regWrEn(regWrEn),
		.regWrPage(regWrPage), .regWrAddr(regWrAddr), .regWrData(regWrData),
		.opDone(opDone), .opReject(opReject), .zeroFlag(zeroFlag),
		.halfCarryFlag(halfCarryFlag), .carryFlag(carryFlag),
		.powerDownFlag(powerDownFlag), .timeoutFlag(timeoutFlag));

	reg_file_model rf (.clk(clk), .regWrEn(regWrEn), .regWrPage(regWrPage),
		.regWrAddr(regWrAddr), .regWrData(regWrData), .regPage(regPage),
		.regAddr(regAddr), .regRdData(regRdData));

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		if (fails == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			fails++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One operation; answer checked in the cycle after the taking edge, then the
	// write-back is let through so the next read sees it
	task automatic step(input op_type o, input page_type p, input logic [5:0] a,
		input logic d, input logic [7:0] v, input logic rej, input logic wr,
		input logic [7:0] wd, input logic [7:0] w, input logic [2:0] zhc);
		rf.poke(p, a, v);
		opCode = o;
		regPage = p;
		regAddr = a;
		destSel = d;
		immData = v;
		opValid = 1'b1;
		@(posedge clk);
		#1 opValid = 1'b0;
		chk({2'h0, opDone, opReject, regWrEn, zeroFlag, halfCarryFlag, carryFlag, workReg},
			{2'h0, ~rej, rej, wr, zhc, w});
		if (wr)
			chk({regWrPage, regWrAddr, regWrData}, {p, a, wd});
		@(posedge clk);
		#1;
	endtask

	// Pulses, power flags, arithmetic flags and work register in one word
	task automatic chk_state(input logic [15:0] exp);
		chk({opDone, opReject, regWrEn, powerDownFlag, timeoutFlag, zeroFlag, halfCarryFlag,
			carryFlag, workReg}, exp);
	endtask

	// Single-cycle watchdog expiry pulse
	task automatic expire();
		watchdogTimeout = 1'b1;
		@(posedge clk);
		#1 watchdogTimeout = 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		chk({6'h0, powerDownFlag, timeoutFlag, workReg}, 16'h0300);
		step(ADD_IMM_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'h12, 0, 0, 8'h00, 8'h12, 3'b000);
		step(ADD_REG_OP, DIRECT_PAGE, 6'h20, 1'b1, 8'h34, 0, 1, 8'h46, 8'h12, 3'b000);
		step(ADD_REG_OP, DIRECT_PAGE, 6'h3f, 1'b1, 8'hf0, 0, 1, 8'h02, 8'h12, 3'b001);
		step(AND_REG_OP, CONTROL_PAGE, 6'h0f, 1'b1, 8'h40, 0, 1, 8'h00, 8'h12, 3'b101);
		step(ADD_REG_WITH_CARRY_OP, CONTROL_PAGE, 6'h05, 1'b1, 8'h34, 0, 1, 8'h47, 8'h12,
			3'b000);
		step(ADD_IMM_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'hfe, 0, 0, 8'h00, 8'h10, 3'b011);
		step(ADD_IMM_WITH_CARRY_OP, DIRECT_PAGE, 6'h00, 1'b1, 8'hef, 0, 0, 8'h00, 8'h00,
			3'b111);
		// Every bit position, flags must survive untouched
		for (int b = 0; b < 8; b++)
		begin
			bitSel = 3'(b);
			step(BIT_CLEAR_OP, DIRECT_PAGE, 6'h01, 1'b1, 8'hff, 0, 1, ~(8'h01 << b), 8'h00,
				3'b111);
		end
		// Out-of-range pages and addresses: refused, nothing written
		for (int i = 0; i < 3; i++)
			step(ADD_REG_OP, rp[i], ra[i], 1'b1, 8'h01, 1, 0, 8'h00, 8'h00, 3'b111);
		step(ADD_IMM_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'h5a, 0, 0, 8'h00, 8'h5a, 3'b000);
		step(AND_REG_OP, SPECIAL_PAGE, 6'h0f, 1'b0, 8'haf, 0, 0, 8'h00, 8'h0a, 3'b000);
		step(ADD_IMM_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'hb0, 0, 0, 8'h00, 8'hba, 3'b000);
		// Subtract: borrow clears carry, no borrow sets it
		step(SUB_REG_OP, DIRECT_PAGE, 6'h02, 1'b0, 8'h05, 0, 0, 8'h00, 8'h4b, 3'b000);
		step(SUB_REG_OP, DIRECT_PAGE, 6'h02, 1'b0, 8'h4b, 0, 0, 8'h00, 8'h00, 3'b111);
		step(SLEEP_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'h00, 0, 0, 8'h00, 8'h00,
			3'b111);
		chk({14'h0, powerDownFlag, timeoutFlag}, 16'h0001);
		expire();
		chk({14'h0, powerDownFlag, timeoutFlag}, 16'h0000);
		step(WATCHDOG_KICK_OP, DIRECT_PAGE, 6'h00, 1'b0, 8'h00, 0, 0, 8'h00, 8'h00,
			3'b111);
		chk({14'h0, powerDownFlag, timeoutFlag}, 16'h0003);
		// Enable low: an offered op and a timeout pulse leave all state frozen
		clkEn = 1'b0;
		opCode = ADD_IMM_OP;
		immData = 8'h33;
		opValid = 1'b1;
		watchdogTimeout = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk_state(16'h1f00);
		// Enable back: the same offer is now taken, no timeout with it
		watchdogTimeout = 1'b0;
		clkEn = 1'b1;
		@(posedge clk);
		#1 opValid = 1'b0;
		chk_state(16'h9833);
		expire();
		chk({14'h0, powerDownFlag, timeoutFlag}, 16'h0002);
		// Reset in mid-run acts as a fresh power-up
		rst_n = 1'b0;
		@(posedge clk);
		#1 rst_n = 1'b1;
		chk_state(16'h1800);
		report_and_stop();
	end
endmodule // tb_mcu_alu_add_and_flags
